// [rtl/ddr_consts.svh]
/*
 * Constants of the burst sequencer: command codes, mode field layout,
 * reset values of the mode settings and latency counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DDR_CONSTS_SVH
`define DDR_CONSTS_SVH

// ************************************************
// Command codes as {ras_n, cas_n, we_n}
// ************************************************
`define CMD_CODE_NOP 3'h7
`define CMD_CODE_ACT 3'h3
`define CMD_CODE_RD 3'h5
`define CMD_CODE_WR 3'h4
`define CMD_CODE_PRE 3'h2
`define CMD_CODE_BST 3'h6
`define CMD_CODE_MRS 3'h0
`define CMD_CODE_REF 3'h1

// ************************************************
// Mode register fields
// ************************************************
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_BT_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 6
`define MODE_SEL_BA 2'h0
`define AP_SEL_BIT 10
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define CL_CODE_2 3'h2
`define CL_CODE_25 3'h6
`define CL_CODE_3 3'h3

// ************************************************
// Latencies in half clock periods, reset values
// ************************************************
`define LAT_HALF_2 4'h4
`define LAT_HALF_25 4'h5
`define LAT_HALF_3 4'h6
`define RST_BL_LOG 2'h1
`define RST_LAT_HALF 4'h4
`define RST_INTERLEAVE 1'h0

`endif

// [rtl/ddr_pkg.sv]
/*
 * Types shared by the burst sequencer and its bench.
 * Assumes nothing of its surroundings.
 */
package ddr_pkg;

	typedef logic [15:0] word_t;

	typedef enum logic [7:0] {
		CMD_NOP = 8'h01,
		CMD_ACT = 8'h02,
		CMD_RD = 8'h04,
		CMD_WR = 8'h08,
		CMD_PRE = 8'h10,
		CMD_BST = 8'h20,
		CMD_MRS = 8'h40,
		CMD_REF = 8'h80
	} cmd_e;

endpackage

// [rtl/ddr_burst_seq.sv]
/*
 * Device-side command and burst sequencer of a four-bank DDR memory.
 * Assumes the link clock and all pins are asynchronous to clock and
 * run well below it; pins are sampled through two flip-flops.
 */
`timescale 1ns/1ps
`include "ddr_consts.svh"

module ddr_burst_seq #(
	parameter int COL_W = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Link clock and command pins
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [11:0] addr,
	input wire logic [1:0] ba,
	// Data pins
	input wire ddr_pkg::word_t dq_in,
	output ddr_pkg::word_t dq_out,
	output logic dq_oe,
	input wire logic dqs_in,
	output logic dqs_out,
	output logic dqs_oe,
	input wire logic upper_byte_write_mask,
	input wire logic lower_byte_write_mask
);
	import ddr_pkg::*;
	localparam int SYNC_W = 38;
	localparam int DEPTH = 4 << COL_W;
	// ************************************************
	// Input synchronisers and edge detection
	// ************************************************
	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;
	logic ck_prev_r;
	logic dqs_prev_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {ck, dqs_in, cs_n, ras_n, cas_n, we_n, addr, ba, dq_in,
				upper_byte_write_mask, lower_byte_write_mask};
			sync_r <= meta_r;
		end
	end
	logic ck_s;
	logic dqs_s;
	logic cs_n_s;
	logic [2:0] code_s;
	logic [11:0] addr_s;
	logic [1:0] ba_s;
	word_t dq_s;
	logic umask_s;
	logic lmask_s;
	assign {ck_s, dqs_s, cs_n_s, code_s, addr_s, ba_s, dq_s, umask_s, lmask_s} = sync_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ck_prev_r <= 1'b0;
			dqs_prev_r <= 1'b0;
		end else begin
			ck_prev_r <= ck_s;
			dqs_prev_r <= dqs_s;
		end
	end
	logic tick;
	logic rise;
	logic dqs_edge;
	assign tick = ck_s ^ ck_prev_r;
	assign rise = ck_s & ~ck_prev_r;
	assign dqs_edge = dqs_s ^ dqs_prev_r;
	// ************************************************
	// Command decode
	// ************************************************
	function automatic cmd_e decode(input logic sel_n, input logic [2:0] code);
		cmd_e c;
		c = CMD_NOP;
		if (!sel_n) begin
			unique case (code)
				`CMD_CODE_ACT: c = CMD_ACT;
				`CMD_CODE_RD: c = CMD_RD;
				`CMD_CODE_WR: c = CMD_WR;
				`CMD_CODE_PRE: c = CMD_PRE;
				`CMD_CODE_BST: c = CMD_BST;
				`CMD_CODE_MRS: c = CMD_MRS;
				`CMD_CODE_REF: c = CMD_REF;
				`CMD_CODE_NOP: c = CMD_NOP;
			endcase
		end
		return c;
	endfunction
	// Column of burst word idx, wrapping inside the burst block
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
			input logic [3:0] idx, input logic [1:0] bl_log, input logic ilv);
		logic [COL_W-1:0] mask;
		logic [COL_W-1:0] off;
		mask = COL_W'((4'h1 << bl_log) - 4'h1);
		off = ilv ? (start ^ COL_W'(idx)) : (start + COL_W'(idx));
		return (start & ~mask) | (off & mask);
	endfunction
	cmd_e cmd;
	logic ap_s;
	assign cmd = rise ? decode(cs_n_s, code_s) : CMD_NOP;
	assign ap_s = addr_s[`AP_SEL_BIT];
	// ************************************************
	// Mode settings
	// ************************************************
	logic [1:0] bl_log_r;
	logic [3:0] lat_half_r;
	logic interleave_r;
	logic [3:0] bl_len;
	assign bl_len = 4'h1 << bl_log_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bl_log_r <= `RST_BL_LOG;
			lat_half_r <= `RST_LAT_HALF;
			interleave_r <= `RST_INTERLEAVE;
		end else if (cmd == CMD_MRS && ba_s == `MODE_SEL_BA) begin
			interleave_r <= addr_s[`MODE_BT_BIT];
			unique case (addr_s[`MODE_BL_MSB:`MODE_BL_LSB])
				`BL_CODE_2: bl_log_r <= 2'h1;
				`BL_CODE_4: bl_log_r <= 2'h2;
				`BL_CODE_8: bl_log_r <= 2'h3;
				default: bl_log_r <= bl_log_r;
			endcase
			unique case (addr_s[`MODE_CL_MSB:`MODE_CL_LSB])
				`CL_CODE_2: lat_half_r <= `LAT_HALF_2;
				`CL_CODE_25: lat_half_r <= `LAT_HALF_25;
				`CL_CODE_3: lat_half_r <= `LAT_HALF_3;
				default: lat_half_r <= lat_half_r;
			endcase
		end
	end
	// ************************************************
	// Pending read or terminate, counted in half periods
	// ************************************************
	logic [3:0] pend_cnt_r;
	logic pend_rd_r;
	logic [COL_W-1:0] pend_col_r;
	logic [1:0] pend_bank_r;
	logic pend_ap_r;
	logic start_evt;
	assign start_evt = tick && pend_cnt_r == 4'h1;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pend_cnt_r <= 4'h0;
			pend_rd_r <= 1'b0;
			pend_col_r <= '0;
			pend_bank_r <= 2'h0;
			pend_ap_r <= 1'b0;
		end else if (cmd == CMD_RD) begin
			pend_cnt_r <= lat_half_r;
			pend_rd_r <= 1'b1;
			pend_col_r <= addr_s[COL_W-1:0];
			pend_bank_r <= ba_s;
			pend_ap_r <= ap_s;
		end else if (cmd == CMD_BST) begin
			pend_cnt_r <= lat_half_r;
			pend_rd_r <= 1'b0;
		end else if (tick && pend_cnt_r != 4'h0) begin
			pend_cnt_r <= pend_cnt_r - 4'h1;
		end
	end
	// ************************************************
	// Read burst output
	// ************************************************
	word_t mem_r [DEPTH];
	logic out_act_r;
	logic [3:0] out_idx_r;
	logic [COL_W-1:0] out_col_r;
	logic [1:0] out_bank_r;
	logic out_ap_r;
	logic rd_end;
	assign rd_end = tick && out_act_r && out_idx_r == bl_len && !start_evt;
	// New burst replaces the old one only when its data is due
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			out_act_r <= 1'b0;
			out_idx_r <= 4'h0;
			out_col_r <= '0;
			out_bank_r <= 2'h0;
			out_ap_r <= 1'b0;
		end else if (start_evt && pend_rd_r) begin
			out_act_r <= 1'b1;
			out_idx_r <= 4'h1;
			out_col_r <= pend_col_r;
			out_bank_r <= pend_bank_r;
			out_ap_r <= pend_ap_r;
		end else if (start_evt || rd_end) begin
			out_act_r <= 1'b0;
		end else if (tick && out_act_r) begin
			out_idx_r <= out_idx_r + 4'h1;
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dq_out <= 16'h0000;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe <= 1'b0;
		end else if (start_evt && pend_rd_r) begin
			dq_out <= mem_r[{pend_bank_r, pend_col_r}];
			dq_oe <= 1'b1;
			dqs_out <= ck_s;
			dqs_oe <= 1'b1;
		end else if (tick && out_act_r && !rd_end && !start_evt) begin
			dq_out <= mem_r[{out_bank_r,
				burst_col(out_col_r, out_idx_r, bl_log_r, interleave_r)}];
			dqs_out <= ck_s;
		end else if (tick) begin
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe <= 1'b0;
		end
	end
	// ************************************************
	// Write burst capture on strobe edges
	// ************************************************
	logic wr_act_r;
	logic [3:0] wr_idx_r;
	logic [COL_W-1:0] wr_col_r;
	logic [1:0] wr_bank_r;
	logic wr_ap_r;
	logic wr_take;
	logic wr_done;
	logic [COL_W-1:0] wr_addr;
	assign wr_take = dqs_edge && wr_act_r && cmd == CMD_NOP;
	assign wr_done = wr_take && wr_idx_r == bl_len - 4'h1;
	assign wr_addr = burst_col(wr_col_r, wr_idx_r, bl_log_r, interleave_r);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_act_r <= 1'b0;
			wr_idx_r <= 4'h0;
			wr_col_r <= '0;
			wr_bank_r <= 2'h0;
			wr_ap_r <= 1'b0;
		end else if (cmd == CMD_WR) begin
			wr_act_r <= 1'b1;
			wr_idx_r <= 4'h0;
			wr_col_r <= addr_s[COL_W-1:0];
			wr_bank_r <= ba_s;
			wr_ap_r <= ap_s;
		end else if (cmd == CMD_RD || cmd == CMD_PRE) begin
			wr_act_r <= 1'b0;
		end else if (wr_take) begin
			wr_act_r <= !wr_done;
			wr_idx_r <= wr_idx_r + 4'h1;
		end
	end
	// Masked bytes keep their old value
	always_ff @(posedge clock) begin
		if (wr_take) begin
			if (!lmask_s) begin
				mem_r[{wr_bank_r, wr_addr}][7:0] <= dq_s[7:0];
			end
			if (!umask_s) begin
				mem_r[{wr_bank_r, wr_addr}][15:8] <= dq_s[15:8];
			end
		end
	end
	// ************************************************
	// Open banks
	// ************************************************
	logic [3:0] bank_open_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bank_open_r <= 4'h0;
		end else if (cmd == CMD_ACT) begin
			bank_open_r[ba_s] <= 1'b1;
		end else if (cmd == CMD_PRE && ap_s) begin
			bank_open_r <= 4'h0;
		end else if (cmd == CMD_PRE) begin
			bank_open_r[ba_s] <= 1'b0;
		end else if (wr_done && wr_ap_r) begin
			bank_open_r[wr_bank_r] <= 1'b0;
		end else if (rd_end && out_ap_r) begin
			bank_open_r[out_bank_r] <= 1'b0;
		end
	end
	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_rd_latency_load: assert property (cmd == CMD_RD |=> pend_cnt_r == $past(lat_half_r)
		&& pend_rd_r) else $error("read latency not loaded");
	a_rd_drive: assert property (start_evt && pend_rd_r |=> dq_oe && dqs_oe
		&& dqs_out == $past(ck_s)) else $error("read data not driven");
	a_bst_stops: assert property (start_evt && !pend_rd_r |=> !dq_oe && !out_act_r)
		else $error("terminate did not stop burst");
	a_rd_interrupt: assert property (start_evt && pend_rd_r |=> out_idx_r == 4'h1
		&& out_col_r == $past(pend_col_r)) else $error("new read not started");
	a_burst_bound: assert property (out_act_r |-> out_idx_r <= bl_len)
		else $error("read burst too long");
	a_rd_end_off: assert property (rd_end |=> !dq_oe && !out_act_r)
		else $error("burst not ended");
	a_wr_restart: assert property (cmd == CMD_WR |=> wr_act_r && wr_idx_r == 4'h0)
		else $error("write not restarted");
	a_wr_step: assert property (wr_take && !wr_done |=> wr_act_r
		&& wr_idx_r == $past(wr_idx_r) + 4'h1) else $error("write word skipped");
	a_wr_cut: assert property (cmd == CMD_RD || cmd == CMD_PRE |=> !wr_act_r)
		else $error("write not truncated");
	a_pre_one: assert property (cmd == CMD_PRE && !ap_s |=> bank_open_r
		== ($past(bank_open_r) & ~(4'h1 << $past(ba_s)))) else $error("bank precharge");
	a_pre_all: assert property (cmd == CMD_PRE && ap_s |=> bank_open_r == 4'h0)
		else $error("precharge all failed");
	a_wr_no_ap: assert property (wr_done && !wr_ap_r && !rd_end |=> bank_open_r
		== $past(bank_open_r)) else $error("bank closed without request");
	c_read_burst: cover property (rd_end);
	c_read_chain: cover property (start_evt && pend_rd_r && out_act_r);
	c_terminate: cover property (start_evt && !pend_rd_r && out_act_r);
	c_write_done: cover property (wr_done);
endmodule

// [dv/ddr_ctrl_model.sv]
/*
 * Controller-side partner: free-running link clock, commands, write
 * bursts on the strobe, and capture of read words with their latency.
 * Assumes the 40 MHz bench clock; the link clock is one eighth of it.
 */
`timescale 1ns/1ps
`include "ddr_consts.svh"
module ddr_ctrl_model (
	// Bench clock
	input wire logic clock,
	// Link clock and commands
	output logic ck,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [11:0] addr,
	output logic [1:0] ba,
	// Write data
	output ddr_pkg::word_t dq_in,
	output logic dqs_in,
	output logic upper_byte_write_mask,
	output logic lower_byte_write_mask,
	// Read data
	input wire ddr_pkg::word_t dq_out,
	input wire logic dq_oe,
	input wire logic dqs_out,
	input wire logic dqs_oe
);
	import ddr_pkg::*;
	logic [2:0] ph = 3'h0;
	logic poe = 1'b0;
	logic pdqs = 1'b0;
	int cyc = 0;
	int t0 = -1;
	int first = 0;
	int rises = 0;
	int oe_diff = 0;
	word_t q[$];
	initial begin
		{ck, cs_n, ras_n, cas_n, we_n, dqs_in} = 6'h3e;
		{addr, ba, dq_in} = 30'h0000_0000;
		{upper_byte_write_mask, lower_byte_write_mask} = 2'h0;
	end
	// ************************************************
	// Link clock, rising when ph leaves 3
	// ************************************************
	always @(posedge clock) begin
		ph <= ph + 3'h1;
		ck <= (ph == 3'h3) ? 1'b1 : ((ph == 3'h7) ? 1'b0 : ck);
		cyc <= cyc + 1;
	end
	// ************************************************
	// Read capture, one word per strobe level
	// ************************************************
	always @(negedge clock) begin
		if (dq_oe === 1'b1 && (poe !== 1'b1 || dqs_out !== pdqs))
			q.push_back(dq_out);
		if (dq_oe === 1'b1 && poe !== 1'b1) begin
			if (rises == 0)
				first = cyc;
			rises++;
		end
		if (dq_oe !== dqs_oe)
			oe_diff++;
		poe = dq_oe;
		pdqs = dqs_out;
	end
	// ************************************************
	// One command at a link rise, then n strobe edges
	// ************************************************
	// Held one link period, then deselected; spacing of two periods keeps
	// mode set, write-to-read and read-terminate-write gaps
	// Also row cycle and write recovery, counted past the last pair
	// Select bit always low on writes
	task automatic op(input logic [2:0] code, input logic [1:0] b, input logic [11:0] a,
		input int n, input word_t base);
		int i;
		do @(posedge clock); while (ph !== 3'h3);
		if (t0 < 0 && code == `CMD_CODE_RD)
			t0 = cyc;
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= code;
		addr <= a;
		ba <= b;
		for (i = 1; i <= 8 + 4 * n; i++) begin
			@(posedge clock);
			if (i == 8) begin
				cs_n <= 1'b1;
				addr <= ~a;
			end
			// Strobe edges between link edges, words in burst order
			if (i >= 6 && (i - 6) % 4 == 0 && (i - 6) / 4 < n) begin
				dqs_in <= ~dqs_in;
				dq_in <= base + 16'((i - 6) / 4);
			end
			if (n > 0 && i == 6 + 4 * n)
				dq_in <= ~dq_in;
		end
	endtask
	// Byte masks, changed well away from any strobe edge
	task automatic set_mask(input logic u, input logic l);
		@(posedge clock);
		upper_byte_write_mask <= u;
		lower_byte_write_mask <= l;
	endtask
endmodule

// [dv/testbench.sv]
/*
 * Self-checking bench of the burst sequencer: writes, chained,
 * interrupted and terminated reads, two latencies and both orders.
 * Assumes the controller model file and the constants header.
 */
`timescale 1ns/1ps
`include "ddr_consts.svh"
module testbench;
	import ddr_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic ck, cs_n, ras_n, cas_n, we_n, dqs_in, um, lm, dq_oe, dqs_out, dqs_oe;
	logic [11:0] addr;
	logic [1:0] ba;
	word_t dq_in, dq_out;
	word_t em [4][16];
	word_t eq[$];
	int bad_count = 0;
	int comparisons = 0;
	always #12.5 clock = ~clock;
	ddr_burst_seq ddr_burst_seq_i (.clock(clock), .rstn(rstn), .ck(ck), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
		.upper_byte_write_mask(um), .lower_byte_write_mask(lm));
	ddr_ctrl_model ddr_ctrl_model_i (.clock(clock), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba), .dq_in(dq_in), .dqs_in(dqs_in),
		.upper_byte_write_mask(um), .lower_byte_write_mask(lm), .dq_out(dq_out),
		.dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));
	// ************************************************
	// Checking and reporting
	// ************************************************
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_w(input word_t got, input word_t exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			bad_count++;
			$display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
		end
	endtask
	// ************************************************
	// Helpers
	// ************************************************
	function automatic int col_of(input int col, input int k, input int bl, input bit il);
		return il ? (col ^ k) : ((col & ~(bl - 1)) | ((col + k) & (bl - 1)));
	endfunction
	task automatic cmd(input logic [2:0] code, input logic [1:0] b, input int col);
		ddr_ctrl_model_i.op(code, b, 12'(col), 0, 16'h0000);
	endtask
	task automatic mode(input logic [2:0] bl, input logic [2:0] cl, input logic il);
		ddr_ctrl_model_i.op(`CMD_CODE_MRS, `MODE_SEL_BA, {5'h00, cl, il, bl}, 0, 16'h0000);
	endtask
	task automatic wr(input int b, input int col, input int n, input int bl, input word_t base);
		ddr_ctrl_model_i.op(`CMD_CODE_WR, 2'(b), 12'(col), n, base);
		for (int k = 0; k < n; k++)
			em[b][col_of(col, k, bl, 1'b0)] = base + 16'(k);
	endtask
	task automatic expect_rd(input int b, input int col, input int bl, input int nw, input bit il);
		for (int k = 0; k < nw; k++)
			eq.push_back(em[b][col_of(col, k, bl, il)]);
	endtask
	// Words, first-word delay in clocks from the command edge, one burst window
	task automatic judge(input int lat, input string name);
		int i;
		for (i = 0; i < 400 && ddr_ctrl_model_i.q.size() < eq.size(); i++)
			@(posedge clock);
		repeat (40) @(posedge clock);
		chk_n(ddr_ctrl_model_i.q.size(), eq.size());
		for (i = 0; i < eq.size() && i < ddr_ctrl_model_i.q.size(); i++)
			chk_w(ddr_ctrl_model_i.q[i], eq[i]);
		chk_n(ddr_ctrl_model_i.first - ddr_ctrl_model_i.t0, 4 * lat + 4);
		chk_n(ddr_ctrl_model_i.rises, 1);
		chk_n(ddr_ctrl_model_i.oe_diff, 0);
		ddr_ctrl_model_i.q.delete();
		eq.delete();
		ddr_ctrl_model_i.rises = 0;
		ddr_ctrl_model_i.oe_diff = 0;
		ddr_ctrl_model_i.t0 = -1;
		$display("test %s done", name);
	endtask
	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_write_read;
		cmd(`CMD_CODE_PRE, 2'h0, 32'h0000_0400);
		mode(`BL_CODE_8, `CL_CODE_2, 1'b0);
		repeat (1600) @(posedge clock);
		cmd(`CMD_CODE_REF, 2'h0, 0);
		cmd(`CMD_CODE_REF, 2'h0, 0);
		cmd(`CMD_CODE_PRE, 2'h0, 32'h0000_0400);
		mode(`BL_CODE_8, `CL_CODE_2, 1'b0);
		cmd(`CMD_CODE_ACT, 2'h0, 0);
		cmd(`CMD_CODE_ACT, 2'h1, 0);
		wr(0, 0, 8, 8, 16'h1000);
		expect_rd(0, 3, 8, 8, 1'b0);
		cmd(`CMD_CODE_RD, 2'h0, 3);
		judge(4, "write_read");
	endtask
	task automatic t_write_trunc;
		wr(1, 0, 8, 8, 16'h2000);
		wr(1, 0, 2, 8, 16'h3000);
		wr(1, 8, 8, 8, 16'h4000);
		expect_rd(1, 0, 8, 4, 1'b0);
		expect_rd(1, 12, 8, 8, 1'b0);
		cmd(`CMD_CODE_RD, 2'h1, 0);
		cmd(`CMD_CODE_RD, 2'h1, 12);
		judge(4, "write_trunc");
	endtask
	task automatic t_reread;
		expect_rd(1, 0, 8, 8, 1'b0);
		cmd(`CMD_CODE_RD, 2'h1, 0);
		judge(4, "reread");
	endtask
	task automatic t_chain4;
		mode(`BL_CODE_4, `CL_CODE_2, 1'b0);
		expect_rd(0, 0, 4, 4, 1'b0);
		expect_rd(1, 4, 4, 4, 1'b0);
		cmd(`CMD_CODE_RD, 2'h0, 0);
		cmd(`CMD_CODE_RD, 2'h1, 4);
		judge(4, "chain4");
	endtask
	task automatic t_cut8;
		mode(`BL_CODE_8, `CL_CODE_2, 1'b0);
		expect_rd(0, 0, 8, 4, 1'b0);
		expect_rd(1, 8, 8, 8, 1'b0);
		cmd(`CMD_CODE_RD, 2'h0, 0);
		cmd(`CMD_CODE_RD, 2'h1, 8);
		judge(4, "cut8");
	endtask
	task automatic t_term;
		expect_rd(0, 2, 8, 4, 1'b0);
		cmd(`CMD_CODE_RD, 2'h0, 2);
		cmd(`CMD_CODE_BST, 2'h0, 0);
		judge(4, "terminate");
	endtask
	task automatic t_cl3_ilv;
		mode(`BL_CODE_4, `CL_CODE_3, 1'b1);
		expect_rd(0, 5, 4, 4, 1'b1);
		cmd(`CMD_CODE_RD, 2'h0, 5);
		judge(6, "cl3_interleaved");
	endtask
	// Precharge cuts a masked burst of 4 after two words; no strobe after the cut
	task automatic t_pre_cut;
		ddr_ctrl_model_i.set_mask(1'b0, 1'b1);
		wr(0, 4, 2, 4, 16'h5000);
		ddr_ctrl_model_i.set_mask(1'b0, 1'b0);
		em[0][4] = 16'h5004;
		em[0][5] = 16'h5005;
		cmd(`CMD_CODE_PRE, 2'h0, 0);
		cmd(`CMD_CODE_ACT, 2'h0, 0);
		expect_rd(0, 4, 4, 4, 1'b1);
		cmd(`CMD_CODE_RD, 2'h0, 4);
		judge(6, "precharge_cut");
	endtask
	// ************************************************
	// Main sequence and watchdog
	// ************************************************
	initial begin
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		t_write_read();
		t_write_trunc();
		t_reread();
		t_chain4();
		t_cut8();
		t_term();
		t_cl3_ilv();
		t_pre_cut();
		end_of_test();
	end
	initial begin
		#200000;
		bad_count++;
		$display("unexpected at %0t: watchdog ran out", $time);
		end_of_test();
	end
endmodule
